// file: verilog/dsps_pin_mux.v
// Pin-sharing logic for the decoder, timer, SPI 0, SPI 1 clock and
// port C / port E general-purpose lines of one pin group.
// Assumes peripherals run on sys_clk and pads resolve out/oe/pull.
`timescale 1ns/1ps
`include "dsps_map.vh"

// Operation
// R01 - After reset every pin selects decoder input or SPI 0 function.
// R02 - Each general-purpose line has its own direction bit.
// R03 - Port C pull bit 7 cleared turns off home 0 pin pull-up.
// R04 - Port E pull bits 4 to 7 control SPI 0 pin pull-ups.
// R05 - Port C pull bit 0 cleared turns off phase A 1 pull-up.
// R06 - SPI clock pins drive out as master, take clock in as slave.
// R07 - Master-out pin drives on master, input on slave; timing by peer.
// R08 - Unselected slave keeps its master-in pin undriven.
// R09 - Master-in pin is input on master; selected slave drives it.
// R10 - External master pulls slave select low to address this slave.
// R11 - SPI 1 clock reaches phase A 1 pin only with alt select set.
// R12 - Home 0 pin offers timer A channel 3 and port C line 7.
// R13 - Phase A 1 pin offers timer B 0, SPI 1 clock, port C line 0.
// R14 - All pull-ups enabled after reset until software clears them.
module dsps_pin_mux
(
   input  wire       sys_clk,
   input  wire       rst_n,
   // Pads
   input  wire [5:0] padIn,
   output reg  [5:0] padOut,
   output reg  [5:0] padOe,
   output reg  [5:0] padPullEn,
   // Pull-up control writes and readback
   input  wire       portCPullupWr,
   input  wire [7:0] portCPullupData,
   output reg  [7:0] port_c_pullup_ctrl,
   input  wire       portEPullupWr,
   input  wire [7:0] portEPullupData,
   output reg  [7:0] port_e_pullup_ctrl,
   // General-purpose line control, one bit per pin of the group
   input  wire       gpioSelWr,
   input  wire [5:0] gpioSelData,
   input  wire       gpioDirWr,
   input  wire [5:0] gpioDirData,
   input  wire       gpioDataWr,
   input  wire [5:0] gpioDataData,
   output reg  [5:0] gpioSelQ,
   output reg  [5:0] gpioDirQ,
   output reg  [5:0] gpioDataQ,
   output wire [5:0] gpioPinState,
   // Timer selects: bit 0 home 0 pin, bit 1 phase A 1 pin
   input  wire       timerSelWr,
   input  wire [1:0] timerSelData,
   output reg  [1:0] timerSelQ,
   // System peripheral-select register, phase A alternate bit
   input  wire       sysPeriphSelWr,
   input  wire       sysPeriphSelData,
   output reg        phase_a_alt_select,
   // Quadrature decoder inputs
   output wire       decoder0_home_in,
   output wire       decoder1_phase_a_in,
   // Timer channels
   input  wire       timerA3Out,
   input  wire       timerA3Oe,
   output wire       timer_a_ch3,
   input  wire       timerB0Out,
   input  wire       timerB0Oe,
   output wire       timer_b_ch0,
   // SPI 0
   input  wire       spi0Master,
   input  wire       spi0SclkOut,
   input  wire       spi0MosiOut,
   input  wire       spi0MisoOut,
   output wire       spi0_serial_clock,
   output wire       spi0_master_out_pin,
   output wire       spi0_master_in_pin,
   output wire       spi0_slave_select_n,
   // SPI 1 clock
   input  wire       spi1Master,
   input  wire       spi1SclkOut,
   output wire       spi1_serial_clock
);

   wire [5:0] pinSync;
   wire [1:0] homeFn;
   wire [1:0] phaseA1Fn;
   wire       spi0Selected;
   reg  [5:0] padOut_d;
   reg  [5:0] padOe_d;

   // ----------------------------------------------------------------
   // Function decode for the decoder pins
   // ----------------------------------------------------------------
   function [1:0] pinFunction;
      input gpioSel;
      input spi1Alt;
      input timerSel;
      begin
         if (gpioSel)
            pinFunction = `DSPS_FN_GPIO;
         else if (spi1Alt)
            pinFunction = `DSPS_FN_SPI1;
         else if (timerSel)
            pinFunction = `DSPS_FN_TIMER;
         else
            pinFunction = `DSPS_FN_DECODER;
      end
   endfunction

   assign homeFn    = pinFunction(gpioSelQ[`DSPS_PIN_HOME], 1'h0,
                                  timerSelQ[0]); // R12
   assign phaseA1Fn = pinFunction(gpioSelQ[`DSPS_PIN_PHA],
                                  phase_a_alt_select,
                                  timerSelQ[1]); // R11 R13

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `DSPS_PIN_COUNT; gi = gi + 1)
      begin : gSync
         dsps_sync3 uSync
         (
            .sys_clk    (sys_clk),
            .rst_n      (rst_n),
            .padLevel   (padIn[gi]),
            .resetLevel (1'h1),
            .syncLevel  (pinSync[gi])
         );
      end
   endgenerate

   assign gpioPinState = pinSync;

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         port_c_pullup_ctrl <= `DSPS_PULLUP_RESET; // R14
         port_e_pullup_ctrl <= `DSPS_PULLUP_RESET; // R14
         gpioSelQ           <= `DSPS_GPIO_SEL_RESET; // R01
         gpioDirQ           <= `DSPS_GPIO_DIR_RESET;
         gpioDataQ          <= `DSPS_GPIO_DATA_RESET;
         timerSelQ          <= `DSPS_TIMER_SEL_RESET; // R01
         phase_a_alt_select <= `DSPS_ALT_SEL_RESET; // R01
      end
      else
      begin
         if (portCPullupWr)
            port_c_pullup_ctrl <= portCPullupData;
         if (portEPullupWr)
            port_e_pullup_ctrl <= portEPullupData;
         if (gpioSelWr)
            gpioSelQ <= gpioSelData;
         if (gpioDirWr)
            gpioDirQ <= gpioDirData; // R02
         if (gpioDataWr)
            gpioDataQ <= gpioDataData;
         if (timerSelWr)
            timerSelQ <= timerSelData;
         if (sysPeriphSelWr)
            phase_a_alt_select <= sysPeriphSelData;
      end
   end

   // ----------------------------------------------------------------
   // Peripheral-facing inputs
   // ----------------------------------------------------------------
   // A pin taken by another function presents an idle level to the
   // peripherals it is not serving.
   assign decoder0_home_in    = (homeFn == `DSPS_FN_DECODER) ?
                                pinSync[`DSPS_PIN_HOME] : 1'h0;
   assign timer_a_ch3         = (homeFn == `DSPS_FN_TIMER) ?
                                pinSync[`DSPS_PIN_HOME] : 1'h0;
   assign decoder1_phase_a_in = (phaseA1Fn == `DSPS_FN_DECODER) ?
                                pinSync[`DSPS_PIN_PHA] : 1'h0;
   assign timer_b_ch0         = (phaseA1Fn == `DSPS_FN_TIMER) ?
                                pinSync[`DSPS_PIN_PHA] : 1'h0;
   assign spi1_serial_clock   = (phaseA1Fn == `DSPS_FN_SPI1) ?
                                pinSync[`DSPS_PIN_PHA] : 1'h0; // R11
   assign spi0_serial_clock   = gpioSelQ[`DSPS_PIN_SCK] ? 1'h0 :
                                pinSync[`DSPS_PIN_SCK]; // R06
   assign spi0_master_out_pin = gpioSelQ[`DSPS_PIN_MOSI] ? 1'h0 :
                                pinSync[`DSPS_PIN_MOSI]; // R07
   assign spi0_master_in_pin  = gpioSelQ[`DSPS_PIN_MISO] ? 1'h0 :
                                pinSync[`DSPS_PIN_MISO]; // R09
   assign spi0_slave_select_n = gpioSelQ[`DSPS_PIN_SSN] ? 1'h1 :
                                pinSync[`DSPS_PIN_SSN]; // R10
   assign spi0Selected        = !spi0_slave_select_n; // R10

   // ----------------------------------------------------------------
   // Pad drive selection
   // ----------------------------------------------------------------
   always @*
   begin
      padOut_d = gpioDataQ;
      padOe_d  = gpioDirQ; // R02
      case (homeFn)
         `DSPS_FN_TIMER:
         begin
            padOut_d[`DSPS_PIN_HOME] = timerA3Out; // R12
            padOe_d[`DSPS_PIN_HOME]  = timerA3Oe; // R12
         end
         `DSPS_FN_GPIO:
         begin
            padOut_d[`DSPS_PIN_HOME] = gpioDataQ[`DSPS_PIN_HOME];
         end
         default:
         begin
            padOut_d[`DSPS_PIN_HOME] = 1'h0;
            padOe_d[`DSPS_PIN_HOME]  = 1'h0; // R01
         end
      endcase
      case (phaseA1Fn)
         `DSPS_FN_TIMER:
         begin
            padOut_d[`DSPS_PIN_PHA] = timerB0Out; // R13
            padOe_d[`DSPS_PIN_PHA]  = timerB0Oe; // R13
         end
         `DSPS_FN_SPI1:
         begin
            padOut_d[`DSPS_PIN_PHA] = spi1SclkOut; // R11
            padOe_d[`DSPS_PIN_PHA]  = spi1Master; // R06
         end
         `DSPS_FN_GPIO:
         begin
            padOut_d[`DSPS_PIN_PHA] = gpioDataQ[`DSPS_PIN_PHA];
         end
         default:
         begin
            padOut_d[`DSPS_PIN_PHA] = 1'h0;
            padOe_d[`DSPS_PIN_PHA]  = 1'h0; // R01
         end
      endcase
      if (!gpioSelQ[`DSPS_PIN_SCK])
      begin
         padOut_d[`DSPS_PIN_SCK] = spi0SclkOut;
         padOe_d[`DSPS_PIN_SCK]  = spi0Master; // R06
      end
      if (!gpioSelQ[`DSPS_PIN_MOSI])
      begin
         padOut_d[`DSPS_PIN_MOSI] = spi0MosiOut;
         padOe_d[`DSPS_PIN_MOSI]  = spi0Master; // R07
      end
      if (!gpioSelQ[`DSPS_PIN_MISO])
      begin
         padOut_d[`DSPS_PIN_MISO] = spi0MisoOut;
         padOe_d[`DSPS_PIN_MISO]  = !spi0Master && spi0Selected; // R08 R09
      end
      if (!gpioSelQ[`DSPS_PIN_SSN])
      begin
         padOut_d[`DSPS_PIN_SSN] = 1'h0;
         padOe_d[`DSPS_PIN_SSN]  = 1'h0; // R10
      end
   end

   // ----------------------------------------------------------------
   // Registered pad outputs
   // ----------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         padOut    <= `DSPS_PAD_RESET;
         padOe     <= `DSPS_PAD_RESET; // R01
         padPullEn <= `DSPS_PULL_EN_RESET; // R14
      end
      else
      begin
         padOut <= padOut_d;
         padOe  <= padOe_d;
         padPullEn[`DSPS_PIN_HOME] <=
            port_c_pullup_ctrl[`DSPS_PUC_HOME_BIT]; // R03
         padPullEn[`DSPS_PIN_PHA]  <=
            port_c_pullup_ctrl[`DSPS_PUC_PHA_BIT]; // R05
         padPullEn[`DSPS_PIN_SCK]  <=
            port_e_pullup_ctrl[`DSPS_PUE_SCK_BIT]; // R04
         padPullEn[`DSPS_PIN_MOSI] <=
            port_e_pullup_ctrl[`DSPS_PUE_MOSI_BIT]; // R04
         padPullEn[`DSPS_PIN_MISO] <=
            port_e_pullup_ctrl[`DSPS_PUE_MISO_BIT]; // R04
         padPullEn[`DSPS_PIN_SSN]  <=
            port_e_pullup_ctrl[`DSPS_PUE_SSN_BIT]; // R04
      end
   end

endmodule // dsps_pin_mux

// file: common/dsps_map.vh
// Constants for the decoder/SPI pin-sharing block: pin indices,
// pull-up bit positions, function codes and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef DSPS_MAP_VH
`define DSPS_MAP_VH

// ----------------------------------------------------------------
// Pin indices within the shared group
// ----------------------------------------------------------------
`define DSPS_PIN_COUNT        6
`define DSPS_PIN_HOME         0
`define DSPS_PIN_SCK          1
`define DSPS_PIN_MOSI         2
`define DSPS_PIN_MISO         3
`define DSPS_PIN_SSN          4
`define DSPS_PIN_PHA          5

// ----------------------------------------------------------------
// Pull-up control bit positions
// ----------------------------------------------------------------
`define DSPS_PUC_HOME_BIT     7
`define DSPS_PUC_PHA_BIT      0
`define DSPS_PUE_SCK_BIT      4
`define DSPS_PUE_MOSI_BIT     5
`define DSPS_PUE_MISO_BIT     6
`define DSPS_PUE_SSN_BIT      7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DSPS_PULLUP_RESET     8'hff
`define DSPS_GPIO_SEL_RESET   6'h00
`define DSPS_GPIO_DIR_RESET   6'h00
`define DSPS_GPIO_DATA_RESET  6'h00
`define DSPS_TIMER_SEL_RESET  2'h0
`define DSPS_ALT_SEL_RESET    1'h0
`define DSPS_PAD_RESET        6'h00
`define DSPS_PULL_EN_RESET    6'h3f

// ----------------------------------------------------------------
// Function codes of a decoder pin
// ----------------------------------------------------------------
`define DSPS_FN_DECODER       2'h0
`define DSPS_FN_TIMER         2'h1
`define DSPS_FN_SPI1          2'h2
`define DSPS_FN_GPIO          2'h3

`endif

// file: verilog/dsps_sync3.v
// Three-flop input synchroniser with agreement filter.
// Assumes an asynchronous pad level and one system clock.
`timescale 1ns/1ps

module dsps_sync3
(
   input  wire sys_clk,
   input  wire rst_n,
   input  wire padLevel,
   input  wire resetLevel,
   output reg  syncLevel
);

   reg stage1_q;
   reg stage2_q;
   reg stage3_q;

   // ----------------------------------------------------------------
   // Synchroniser chain
   // ----------------------------------------------------------------
   // The output takes a new level only when the second and third
   // stages agree; the first stage feeds the second and nothing else.
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         stage1_q  <= resetLevel;
         stage2_q  <= resetLevel;
         stage3_q  <= resetLevel;
         syncLevel <= resetLevel;
      end
      else
      begin
         stage1_q <= padLevel;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         if (stage2_q == stage3_q)
         begin
            syncLevel <= stage3_q;
         end
      end
   end

endmodule // dsps_sync3

// file: verification/dsps_pin_mux_asserts.sv
// Checker for the decoder/SPI pin-sharing block, bound to its ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps

module dsps_pin_mux_asserts
(
   input wire       sys_clk,
   input wire       rst_n,
   input wire [5:0] padOe,
   input wire [5:0] padPullEn,
   input wire       portCPullupWr,
   input wire [7:0] portCPullupData,
   input wire [7:0] port_c_pullup_ctrl,
   input wire [7:0] port_e_pullup_ctrl,
   input wire [5:0] gpioSelQ,
   input wire [5:0] gpioDirQ,
   input wire [1:0] timerSelQ,
   input wire       phase_a_alt_select,
   input wire       timer_a_ch3,
   input wire       spi0Master,
   input wire       spi0_slave_select_n,
   input wire       spi1_serial_clock
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   AST_RESET_STATE: assert property (disable iff (1'b0)
      !rst_n |=> padPullEn == 6'h3f && padOe == 6'h00 &&
      gpioSelQ == 6'h00 && port_c_pullup_ctrl == 8'hff)
      else $error("Reset state wrong");
   AST_PC_WRITE: assert property (portCPullupWr
      |=> port_c_pullup_ctrl == $past(portCPullupData))
      else $error("Port C pull-up write lost");
   AST_PULL_PC: assert property (
      padPullEn[0] == $past(port_c_pullup_ctrl[7]) &&
      padPullEn[5] == $past(port_c_pullup_ctrl[0]))
      else $error("Port C pull enable wrong");
   AST_PULL_PE: assert property (
      padPullEn[4:1] == $past(port_e_pullup_ctrl[7:4]))
      else $error("Port E pull enable wrong");
   AST_SPI0_OE: assert property ($past(rst_n) && !$past(gpioSelQ[1])
      && !$past(gpioSelQ[2]) |-> padOe[2:1] == {2{$past(spi0Master)}})
      else $error("SPI 0 clock or data-out direction wrong");
   AST_MISO_OE: assert property ($past(rst_n) && !$past(gpioSelQ[3])
      |-> padOe[3] == (!$past(spi0Master) && !$past(spi0_slave_select_n)))
      else $error("SPI 0 data-in pin drive wrong");
   AST_GPIO_DIR: assert property ($past(rst_n)
      |-> ((padOe ^ $past(gpioDirQ)) & $past(gpioSelQ)) == 6'h00)
      else $error("Line direction wrong");
   AST_SPI1_ROUTE: assert property (spi1_serial_clock
      |-> phase_a_alt_select && !gpioSelQ[5])
      else $error("SPI 1 clock routed without select");
   AST_TIMER_A: assert property (timer_a_ch3
      |-> timerSelQ[0] && !gpioSelQ[0])
      else $error("Timer A channel routed without select");

   CV_MISO: cover property (padOe[3]);
   CV_SPI1: cover property (spi1_serial_clock);
   CV_GPIO: cover property (gpioSelQ != 6'h00 && padOe != 6'h00);
endmodule // dsps_pin_mux_asserts

bind dsps_pin_mux dsps_pin_mux_asserts chk_u (.sys_clk, .rst_n, .padOe,
   .padPullEn, .portCPullupWr, .portCPullupData, .port_c_pullup_ctrl,
   .port_e_pullup_ctrl, .gpioSelQ, .gpioDirQ, .timerSelQ,
   .phase_a_alt_select, .timer_a_ch3, .spi0Master, .spi0_slave_select_n,
   .spi1_serial_clock);

// file: verification/dsps_peer.sv
// External SPI peer and encoder model resolving the six pad wires.
// Assumes pad drive, enable and pull come from the pin-sharing block.
`timescale 1ns/1ps

module dsps_peer
(
   input  wire       sys_clk,
   input  wire [5:0] padOut,
   input  wire [5:0] padOe,
   input  wire [5:0] padPullEn,
   input  wire [5:0] peerVal,
   input  wire [5:0] peerOe,
   output reg  [5:0] padIn
);
   reg [5:0] floatQ = 6'h15;

   // An undriven line without pull-up wanders every cycle.
   always @(posedge sys_clk)
   begin
      floatQ <= ~floatQ;
   end

   always @*
   begin
      padIn = padOe & padOut | ~padOe & peerOe & peerVal
            | ~padOe & ~peerOe & (padPullEn | floatQ);
   end
endmodule // dsps_peer

// file: verification/dsps_pin_mux_bench.sv
// Self-checking bench for the decoder/SPI pin-sharing block.
// Assumes the peer model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
$display("CHECK FAILED %0t got %h want %h", $time, a, b); end end

module dsps_pin_mux_bench;
   logic       sys_clk = 0, rst_n = 0, cWr = 0, eWr = 0, sWr = 0, dWr = 0;
   logic       vWr = 0, tWr = 0, aWr = 0, aDat = 0, altQ, m0 = 0, m1 = 0;
   logic       a3o = 0, a3e = 0, b0o = 0, b0e = 0, sck0 = 0, mo0 = 0;
   logic       mi0 = 0, sck1 = 0;
   logic [7:0] cDat = 0, eDat = 0, pcQ, peQ;
   logic [5:0] sDat = 0, dDat = 0, vDat = 0, gsQ, gdQ, gvQ, pinQ;
   logic [5:0] padIn, padOut, padOe, padPullEn, peerVal = 0, peerOe = 6'h10;
   logic [1:0] tDat = 0, tsQ;
   wire  [8:0] fn;
   int         miscompares = 0, check_count = 0, pc, pe, gs, gd, gv, ts, alt;

   dsps_pin_mux dut_u (.sys_clk, .rst_n, .padIn, .padOut, .padOe, .padPullEn,
      .portCPullupWr(cWr), .portCPullupData(cDat), .port_c_pullup_ctrl(pcQ),
      .portEPullupWr(eWr), .portEPullupData(eDat), .port_e_pullup_ctrl(peQ),
      .gpioSelWr(sWr), .gpioSelData(sDat), .gpioDirWr(dWr),
      .gpioDirData(dDat), .gpioDataWr(vWr), .gpioDataData(vDat),
      .gpioSelQ(gsQ), .gpioDirQ(gdQ), .gpioDataQ(gvQ), .gpioPinState(pinQ),
      .timerSelWr(tWr), .timerSelData(tDat), .timerSelQ(tsQ),
      .sysPeriphSelWr(aWr), .sysPeriphSelData(aDat), .phase_a_alt_select(altQ),
      .decoder0_home_in(fn[8]), .timer_a_ch3(fn[7]),
      .decoder1_phase_a_in(fn[6]), .timer_b_ch0(fn[5]),
      .spi1_serial_clock(fn[4]), .spi0_serial_clock(fn[1]),
      .spi0_master_out_pin(fn[2]), .spi0_master_in_pin(fn[3]),
      .spi0_slave_select_n(fn[0]), .timerA3Out(a3o), .timerA3Oe(a3e),
      .timerB0Out(b0o), .timerB0Oe(b0e), .spi0Master(m0), .spi0SclkOut(sck0),
      .spi0MosiOut(mo0), .spi0MisoOut(mi0), .spi1Master(m1),
      .spi1SclkOut(sck1));
   dsps_peer peer_u (.sys_clk, .padOut, .padOe, .padPullEn, .peerVal,
      .peerOe, .padIn);

   function automatic logic [5:0] res(logic [5:0] oe, out, pull);
      return oe & out | ~oe & peerOe & peerVal | ~oe & ~peerOe & pull;
   endfunction

   // Expected pads and peripheral views; pins left floating are masked.
   task automatic check();
      logic [5:0] g, oe, out, pull, w, def;
      logic [8:0] f, fm;
      logic       ss;
      g = gs;
      pull = {pc[0], pe[7:4], pc[7]};
      oe = g & gd;
      out = gv;
      if (!g[0]) {oe[0], out[0]} = {ts[0] & a3e, a3o};
      if (!g[1]) {oe[1], out[1]} = {m0, sck0};
      if (!g[2]) {oe[2], out[2]} = {m0, mo0};
      if (!g[5]) {oe[5], out[5]} = alt ? {m1, sck1} : {ts[1] & b0e, b0o};
      w = res(oe, out, pull);
      ss = g[4] | w[4];
      if (!g[3]) {oe[3], out[3]} = {!m0 & !ss, mi0};
      w = res(oe, out, pull);
      def = oe | peerOe | pull;
      f = {!g[0] & !ts[0] & w[0], !g[0] & ts[0] & w[0],
           !g[5] & !alt & !ts[1] & w[5], !g[5] & !alt & ts[1] & w[5],
           !g[5] & alt[0] & w[5], ~g[3:1] & w[3:1], ss};
      fm = {def[0], def[0], def[5], def[5], def[5], def[3:1], 1'b1};
      `CHK({pcQ, peQ}, {pc[7:0], pe[7:0]})
      `CHK({gsQ, gdQ, gvQ}, {g, gd[5:0], gv[5:0]})
      `CHK({tsQ, altQ}, {ts[1:0], alt[0]})
      `CHK(padPullEn, pull)
      `CHK(padOe, oe)
      `CHK(padOut & oe, out & oe)
      `CHK(pinQ & def, w & def)
      `CHK(fn & fm, f & fm)
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   initial
   begin
      repeat (6000) @(posedge sys_clk);
      miscompares++;
      stop_test();
   end

   initial
   begin
      void'($urandom(64));
      for (int i = 0; i < 300; i++)
      begin
         if (i == 0 || i == 150)
         begin
            rst_n = 0;
            repeat (4) @(negedge sys_clk);
            rst_n = 1;
            {pc, pe} = {32'hff, 32'hff};
            {gs, gd, gv, ts, alt} = '0;
            repeat (12) @(negedge sys_clk);
            check();
         end
         repeat (2)
         begin
            {cWr, eWr, sWr, dWr, vWr, tWr, aWr} = $urandom;
            {cDat, eDat} = $urandom;
            {sDat, dDat, vDat, tDat, aDat} = $urandom;
            if (cWr) pc = cDat;
            if (eWr) pe = eDat;
            if (sWr) gs = sDat;
            if (dWr) gd = dDat;
            if (vWr) gv = vDat;
            if (tWr) ts = tDat;
            if (aWr) alt = aDat;
            @(negedge sys_clk);
         end
         {cWr, eWr, sWr, dWr, vWr, tWr, aWr} = 7'h00;
         {m0, m1, a3o, a3e, b0o, b0e, sck0, mo0, mi0, sck1} = $urandom;
         peerOe = $urandom | 6'h10;
         peerVal = $urandom;
         repeat (10) @(negedge sys_clk);
         check();
      end
      stop_test();
   end
endmodule // dsps_pin_mux_bench
